// File: include/c8dec_cfg.svh
// constants of the opcode decode tail: opcodes, cycle counts, flag bits
// assumes inclusion by bare name from the package and the properties file
`ifndef C8DEC_CFG_SVH
`define C8DEC_CFG_SVH
`define C8DEC_OP_TST_DIR 8'h3d
`define C8DEC_OP_TST_A 8'h4d
`define C8DEC_OP_TST_X 8'h5d
`define C8DEC_OP_TST_IX1 8'h6d
`define C8DEC_OP_TST_IX 8'h7d
`define C8DEC_OP_WAIT 8'h8f
`define C8DEC_OP_TXA 8'h9f
`define C8DEC_CYC_TST_DIR 4'h4
`define C8DEC_CYC_TST_INH 4'h3
`define C8DEC_CYC_TST_IX1 4'h5
`define C8DEC_CYC_TST_IX 4'h4
`define C8DEC_CYC_INH2 4'h2
`define C8DEC_CYC_DEFAULT 4'h2
`define C8DEC_CCR_C 0
`define C8DEC_CCR_Z 1
`define C8DEC_CCR_N 2
`define C8DEC_CCR_I 3
`define C8DEC_CCR_H 4
`define C8DEC_CCR_RST 5'h08
`define C8DEC_COL_BITTST 4'h0
`define C8DEC_COL_REL 4'h2
`define C8DEC_COL_IMM 4'ha
`define C8DEC_COL_DIR 4'hb
`define C8DEC_COL_EXT 4'hc
`define C8DEC_COL_IX2 4'hd
`define C8DEC_COL_IX1 4'he
`define C8DEC_COL_IX 4'hf
`endif

// File: include/c8dec_pkg.sv
// types shared by the decode tail: addressing modes, operations, decode
// assumes c8dec_cfg.svh on the include path
package c8dec_pkg;
`include "c8dec_cfg.svh"
    typedef enum logic [2:0] {
        C8DEC_MODE_INH = 3'h0,
        C8DEC_MODE_IMM = 3'h1,
        C8DEC_MODE_DIR = 3'h2,
        C8DEC_MODE_EXT = 3'h3,
        C8DEC_MODE_IX2 = 3'h4,
        C8DEC_MODE_IX1 = 3'h5,
        C8DEC_MODE_IX = 3'h6,
        C8DEC_MODE_REL = 3'h7
    } c8dec_mode_e;
    typedef enum logic [3:0] {
        C8DEC_OP_SUB = 4'h0,
        C8DEC_OP_CMP = 4'h1,
        C8DEC_OP_SBC = 4'h2,
        C8DEC_OP_CPX = 4'h3,
        C8DEC_OP_AND = 4'h4,
        C8DEC_OP_BIT = 4'h5,
        C8DEC_OP_LDA = 4'h6,
        C8DEC_OP_STA = 4'h7,
        C8DEC_OP_TSTZN = 4'h8,
        C8DEC_OP_TXA = 4'h9,
        C8DEC_OP_WAIT = 4'ha,
        C8DEC_OP_BRSET = 4'hb,
        C8DEC_OP_BRANCH = 4'hc,
        C8DEC_OP_NONE = 4'hf
    } c8dec_op_e;
    typedef struct packed {
        c8dec_mode_e mode;
        c8dec_op_e op;
        logic [1:0] addr_bytes;
        logic [3:0] cycles;
        logic src_x;
        logic src_a;
        logic known;
    } c8dec_dec_s;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] x;
        logic [4:0] condition_code_reg;
    } c8dec_regs_s;
endpackage

// File: rtl/c8dec_core.sv
// fetch/execute sequencer for the decode tail of an 8-bit accumulator cpu
// assumes program memory answers a read in the same cycle (mem_rdata_i)
`timescale 1ns/1ns
module c8dec_core
    import c8dec_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // program and data memory
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic mem_rd_o,
    input wire logic [7:0] mem_rdata_i,
    // interrupt request and status
    input wire logic irq_i,
    output logic waiting_o,
    output logic undef_op_o,
    // architectural state view
    output c8dec_regs_s regs_o,
    output logic [ADDR_W-1:0] pc_o,
    output logic [ADDR_W-1:0] ea_o,
    output logic branch_cond_i_unused_o
);
    typedef enum logic [2:0] {
        C8DEC_ST_FETCH = 3'b000,
        C8DEC_ST_ADDR = 3'b001,
        C8DEC_ST_OPER = 3'b011,
        C8DEC_ST_EXEC = 3'b010,
        C8DEC_ST_WAIT = 3'b110
    } c8dec_st_e;

    typedef struct packed {
        c8dec_st_e st;
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] ea;
        logic [7:0] opcode;
        logic [7:0] oper;
        logic [1:0] left;
        logic [3:0] cnt;
        c8dec_regs_s regs;
        logic undef;
    } c8dec_state_s;

    c8dec_state_s s_q, s_d;
    c8dec_dec_s dec, dec_q;
    logic [7:0] fetch_op;

    // the address shifter keeps a full high byte, so narrower buses fail
    if (ADDR_W < 16) begin : g_addr_w_chk
        $error("c8dec_core: ADDR_W must be at least 16");
    end

    assign fetch_op = (s_q.st == C8DEC_ST_FETCH) ? mem_rdata_i : s_q.opcode;

    c8dec_decode u_decode (
        .opcode_i(fetch_op),
        .dec_o(dec)
    );

    c8dec_decode u_decode_q (
        .opcode_i(s_q.opcode),
        .dec_o(dec_q)
    );

    function automatic logic [ADDR_W-1:0] add_pc(input logic [ADDR_W-1:0] a,
                                                 input logic [7:0] b);
        add_pc = a + ADDR_W'(b);
    endfunction

    function automatic logic [4:0] set_nz(input logic [4:0] c,
                                          input logic [7:0] v);
        set_nz = c;
        set_nz[`C8DEC_CCR_N] = v[7];
        set_nz[`C8DEC_CCR_Z] = (v == 8'h00);
    endfunction

    always_comb begin
        s_d = s_q;
        case (s_q.st)
            C8DEC_ST_FETCH: begin
                s_d.opcode = mem_rdata_i;
                s_d.pc = add_pc(s_q.pc, 8'h01);
                s_d.undef = ~dec.known;
                s_d.left = dec.addr_bytes;
                s_d.cnt = dec.cycles - 4'h1;
                // ea keeps the last operand address across inherent ops
                if (dec.mode == C8DEC_MODE_IX) begin
                    s_d.ea = ADDR_W'(s_q.regs.x);
                    s_d.st = C8DEC_ST_OPER;
                end else if (dec.addr_bytes != 2'h0
                             || dec.mode == C8DEC_MODE_IMM
                             || dec.mode == C8DEC_MODE_REL) begin
                    s_d.ea = '0;
                    s_d.st = C8DEC_ST_ADDR;
                end else begin
                    s_d.st = C8DEC_ST_EXEC;
                end
            end
            C8DEC_ST_ADDR: begin
                s_d.pc = add_pc(s_q.pc, 8'h01);
                s_d.cnt = s_q.cnt - 4'h1;
                if (dec_q.mode == C8DEC_MODE_IMM
                    || dec_q.mode == C8DEC_MODE_REL) begin
                    s_d.oper = mem_rdata_i;
                    s_d.st = C8DEC_ST_EXEC;
                end else begin
                    // high byte arrives first, low byte shifts in last
                    s_d.ea = {s_q.ea[ADDR_W-9:0], mem_rdata_i};
                    s_d.left = s_q.left - 2'h1;
                    if (s_q.left == 2'h1) begin
                        s_d.st = C8DEC_ST_OPER;
                        if (dec_q.mode == C8DEC_MODE_IX1) begin
                            s_d.ea = ADDR_W'(s_q.regs.x)
                                     + ADDR_W'(mem_rdata_i);
                        end else if (dec_q.mode == C8DEC_MODE_IX2) begin
                            s_d.ea = {s_q.ea[ADDR_W-9:0], mem_rdata_i}
                                     + ADDR_W'(s_q.regs.x);
                        end
                    end
                end
            end
            C8DEC_ST_OPER: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (dec_q.op == C8DEC_OP_BRSET) begin
                    s_d.oper = mem_rdata_i;
                    s_d.st = C8DEC_ST_ADDR;
                    s_d.opcode = {4'h2, 4'h0};
                end else begin
                    s_d.oper = mem_rdata_i;
                    s_d.st = C8DEC_ST_EXEC;
                end
            end
            C8DEC_ST_EXEC: begin
                s_d.cnt = (s_q.cnt == 4'h0) ? 4'h0 : s_q.cnt - 4'h1;
                if (s_q.cnt <= 4'h1) begin
                    s_d.st = C8DEC_ST_FETCH;
                    case (dec_q.op)
                        C8DEC_OP_TSTZN: begin
                            s_d.regs.condition_code_reg = set_nz(s_q.regs.condition_code_reg,
                                dec_q.src_a ? s_q.regs.a :
                                dec_q.src_x ? s_q.regs.x : s_q.oper);
                        end
                        C8DEC_OP_TXA: s_d.regs.a = s_q.regs.x;
                        C8DEC_OP_WAIT: begin
                            s_d.regs.condition_code_reg[`C8DEC_CCR_I] = 1'b0;
                            s_d.st = C8DEC_ST_WAIT;
                        end
                        C8DEC_OP_LDA: begin
                            s_d.regs.a = s_q.oper;
                            s_d.regs.condition_code_reg = set_nz(s_q.regs.condition_code_reg, s_q.oper);
                        end
                        C8DEC_OP_AND: begin
                            s_d.regs.a = s_q.regs.a & s_q.oper;
                            s_d.regs.condition_code_reg = set_nz(s_q.regs.condition_code_reg,
                                                  s_q.regs.a & s_q.oper);
                        end
                        C8DEC_OP_BIT: begin
                            s_d.regs.condition_code_reg = set_nz(s_q.regs.condition_code_reg,
                                                  s_q.regs.a & s_q.oper);
                        end
                        C8DEC_OP_BRANCH: begin
                            s_d.pc = s_q.pc
                                + ADDR_W'(signed'(s_q.oper));
                        end
                        default: ;
                    endcase
                end
            end
            C8DEC_ST_WAIT: begin
                // sequencer state held: nothing advances until an interrupt
                if (irq_i) begin
                    s_d.st = C8DEC_ST_FETCH;
                end
            end
            default: s_d.st = C8DEC_ST_FETCH;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
            s_q.regs.condition_code_reg <= `C8DEC_CCR_RST;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        case (s_q.st)
            C8DEC_ST_OPER: mem_addr_o = s_q.ea;
            default: mem_addr_o = s_q.pc;
        endcase
    end

    assign mem_rd_o = (s_q.st != C8DEC_ST_WAIT) && (s_q.st != C8DEC_ST_EXEC);
    assign waiting_o = (s_q.st == C8DEC_ST_WAIT);
    assign undef_op_o = s_q.undef;
    assign regs_o = s_q.regs;
    assign pc_o = s_q.pc;
    assign ea_o = s_q.ea;
    assign branch_cond_i_unused_o = 1'b0;
endmodule // c8dec_core

// File: rtl/c8dec_decode.sv
// combinational opcode decoder: class, addressing mode, operation, cycles
// assumes an 8-bit opcode presented when it is fetched
`timescale 1ns/1ns
module c8dec_decode
    import c8dec_pkg::*;
(
    // opcode in
    input wire logic [7:0] opcode_i,
    // decoded fields out
    output c8dec_dec_s dec_o
);
    always_comb begin
        dec_o = '{mode: C8DEC_MODE_INH, op: C8DEC_OP_NONE, addr_bytes: 2'h0,
                  cycles: `C8DEC_CYC_DEFAULT, src_x: 1'b0, src_a: 1'b0,
                  known: 1'b0};
        // high nibble picks class and mode
        case (opcode_i[7:4])
            `C8DEC_COL_BITTST: begin
                dec_o.mode = C8DEC_MODE_DIR;
                dec_o.op = C8DEC_OP_BRSET;
                dec_o.addr_bytes = 2'h1;
                dec_o.known = ~opcode_i[0];
            end
            `C8DEC_COL_REL: begin
                dec_o.mode = C8DEC_MODE_REL;
                dec_o.op = C8DEC_OP_BRANCH;
                dec_o.known = 1'b1;
            end
            `C8DEC_COL_IMM: dec_o.mode = C8DEC_MODE_IMM;
            `C8DEC_COL_DIR: dec_o.mode = C8DEC_MODE_DIR;
            `C8DEC_COL_EXT: dec_o.mode = C8DEC_MODE_EXT;
            `C8DEC_COL_IX2: dec_o.mode = C8DEC_MODE_IX2;
            `C8DEC_COL_IX1: dec_o.mode = C8DEC_MODE_IX1;
            `C8DEC_COL_IX: dec_o.mode = C8DEC_MODE_IX;
            default: dec_o.mode = C8DEC_MODE_INH;
        endcase
        // register/memory columns: low nibble 0..7 picks the operation
        if (opcode_i[7:4] >= `C8DEC_COL_IMM && !opcode_i[3]) begin
            dec_o.op = c8dec_op_e'({1'b0, opcode_i[2:0]});
            dec_o.known = !(dec_o.mode == C8DEC_MODE_IMM
                            && opcode_i[2:0] == 3'h7);
        end
        case (dec_o.mode)
            C8DEC_MODE_DIR, C8DEC_MODE_IX1: dec_o.addr_bytes = 2'h1;
            C8DEC_MODE_EXT, C8DEC_MODE_IX2: dec_o.addr_bytes = 2'h2;
            default: dec_o.addr_bytes = 2'h0;
        endcase
        case (opcode_i)
            `C8DEC_OP_TST_DIR: begin
                dec_o = '{C8DEC_MODE_DIR, C8DEC_OP_TSTZN, 2'h1,
                          `C8DEC_CYC_TST_DIR, 1'b0, 1'b0, 1'b1};
            end
            `C8DEC_OP_TST_A: begin
                dec_o = '{C8DEC_MODE_INH, C8DEC_OP_TSTZN, 2'h0,
                          `C8DEC_CYC_TST_INH, 1'b0, 1'b1, 1'b1};
            end
            `C8DEC_OP_TST_X: begin
                dec_o = '{C8DEC_MODE_INH, C8DEC_OP_TSTZN, 2'h0,
                          `C8DEC_CYC_TST_INH, 1'b1, 1'b0, 1'b1};
            end
            `C8DEC_OP_TST_IX1: begin
                dec_o = '{C8DEC_MODE_IX1, C8DEC_OP_TSTZN, 2'h1,
                          `C8DEC_CYC_TST_IX1, 1'b0, 1'b0, 1'b1};
            end
            `C8DEC_OP_TST_IX: begin
                dec_o = '{C8DEC_MODE_IX, C8DEC_OP_TSTZN, 2'h0,
                          `C8DEC_CYC_TST_IX, 1'b0, 1'b0, 1'b1};
            end
            `C8DEC_OP_TXA: begin
                dec_o = '{C8DEC_MODE_INH, C8DEC_OP_TXA, 2'h0,
                          `C8DEC_CYC_INH2, 1'b0, 1'b0, 1'b1};
            end
            `C8DEC_OP_WAIT: begin
                dec_o = '{C8DEC_MODE_INH, C8DEC_OP_WAIT, 2'h0,
                          `C8DEC_CYC_INH2, 1'b0, 1'b0, 1'b1};
            end
            default: ;
        endcase
    end
endmodule // c8dec_decode

// File: verification/c8dec_core_properties.sv
// assertions on the ports of the decode tail core
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ns
`include "c8dec_cfg.svh"
module c8dec_core_properties
    import c8dec_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // watched ports
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic irq_i,
    input wire logic waiting_o,
    input wire c8dec_regs_s regs_o,
    input wire logic [ADDR_W-1:0] pc_o
);
    logic rd_q;
    logic fetch;
    always_ff @(posedge ref_clk_i or negedge rstn_i)
        if (!rstn_i) rd_q <= 1'b1;
        else rd_q <= mem_rd_o;
    // only fetches after a quiet cycle are seen; the first after reset is not
    assign fetch = mem_rd_o && !rd_q && mem_addr_o == pc_o;
    default clocking dcb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_take(logic [7:0] op);
        fetch && mem_rdata_i == op;
    endsequence
    sequence s_zn(logic [7:0] v);
        fetch && regs_o.condition_code_reg[`C8DEC_CCR_Z] == (v == 8'h00)
            && regs_o.condition_code_reg[`C8DEC_CCR_N] == (v >= 8'h80);
    endsequence
    property p_txa;
        s_take(8'h9f) |=> !fetch ##1 (fetch && regs_o.a == regs_o.x
            && regs_o.condition_code_reg == $past(regs_o.condition_code_reg, 2));
    endproperty
    property p_tsta;
        s_take(8'h4d) |=> (!fetch)[*2] ##1 s_zn(regs_o.a);
    endproperty
    property p_tstx;
        s_take(8'h5d) |=> (!fetch)[*2] ##1 s_zn(regs_o.x);
    endproperty
    property p_tst_ix1;
        s_take(8'h6d) |=> (!fetch)[*4] ##1 fetch;
    endproperty
    property p_tst_ix;
        s_take(8'h7d) |=> (!fetch)[*3] ##1 fetch;
    endproperty
    property p_tst_dir;
        s_take(8'h3d) |=> mem_rd_o ##1 (mem_rd_o
            && mem_addr_o == {8'h00, $past(mem_rdata_i)})
            ##1 !fetch ##1 s_zn($past(mem_rdata_i, 2));
    endproperty
    property p_ext;
        s_take(8'hc6) |=> mem_rd_o ##1 mem_rd_o ##1 (mem_rd_o
            && mem_addr_o == {$past(mem_rdata_i, 2), $past(mem_rdata_i)});
    endproperty
    property p_ix2;
        s_take(8'hd6) |=> ##2 (mem_rd_o && mem_addr_o == {$past(mem_rdata_i,
            2), $past(mem_rdata_i)} + {8'h00, regs_o.x});
    endproperty
    property p_ix1;
        s_take(8'he6) |=> ##1 (mem_rd_o
            && mem_addr_o == {8'h00, $past(mem_rdata_i)} + {8'h00, regs_o.x});
    endproperty
    property p_ix;
        s_take(8'hf6) |=> mem_rd_o && mem_addr_o == {8'h00, regs_o.x};
    endproperty
    property p_wait;
        s_take(8'h8f) |-> ##2 (waiting_o && !mem_rd_o
            && !regs_o.condition_code_reg[`C8DEC_CCR_I]);
    endproperty
    property p_wait_hold;
        waiting_o && !irq_i |=> waiting_o && !mem_rd_o;
    endproperty
    property p_wake;
        waiting_o && irq_i |=> !waiting_o && mem_rd_o && mem_addr_o == pc_o;
    endproperty
    a_txa: assert property (p_txa) else $error("txa wrong");
    a_tsta: assert property (p_tsta) else $error("tsta wrong");
    a_tstx: assert property (p_tstx) else $error("tstx wrong");
    a_tst_ix1: assert property (p_tst_ix1) else $error("tst ix1");
    a_tst_ix: assert property (p_tst_ix) else $error("tst ix");
    a_tst_dir: assert property (p_tst_dir) else $error("tst dir");
    a_ext: assert property (p_ext) else $error("ext address");
    a_ix2: assert property (p_ix2) else $error("ix2 address");
    a_ix1: assert property (p_ix1) else $error("ix1 address");
    a_ix: assert property (p_ix) else $error("ix address");
    a_wait: assert property (p_wait) else $error("wait entry");
    a_wait_hold: assert property (p_wait_hold) else $error("hold");
    a_wake: assert property (p_wake) else $error("wake");
endmodule // c8dec_core_properties
bind c8dec_core c8dec_core_properties #(.ADDR_W(ADDR_W)) u_props (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i), .irq_i(irq_i),
    .waiting_o(waiting_o), .regs_o(regs_o), .pc_o(pc_o));

// File: verification/c8dec_prog_mem.sv
// program memory model: one byte array read in the same cycle
// assumes the core holds address and read strobe for the whole cycle
`timescale 1ns/1ns
module c8dec_prog_mem (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // read port
    input wire logic [15:0] mem_addr_i,
    input wire logic mem_rd_i,
    output logic [7:0] mem_rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    initial for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ 8'ha5;
    // without a read the bus shows the inverted last byte, so a core
    // that samples outside its strobe cannot get lucky
    assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~last_q;
    always_ff @(posedge ref_clk_i or negedge rstn_i)
        if (!rstn_i) last_q <= 8'h00;
        else if (mem_rd_i) last_q <= mem[mem_addr_i];
endmodule // c8dec_prog_mem

// File: verification/tb_cpu8_opcode_decode_tail.sv
// self-checking bench for the decode tail core with a program memory
// assumes each program ends in the wait opcode so completion is visible
`timescale 1ns/1ns
module tb_cpu8_opcode_decode_tail;
    import c8dec_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic irq_i = 1'b0;
    logic [15:0] mem_addr_o;
    logic [15:0] pc_o;
    logic [15:0] ea_o;
    logic mem_rd_o;
    logic waiting_o;
    logic undef_op_o;
    logic [7:0] mem_rdata_i;
    c8dec_regs_s regs_o;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    initial forever #2 ref_clk_i = ~ref_clk_i;
    c8dec_core #(.ADDR_W(16)) u_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
        .mem_rdata_i(mem_rdata_i), .irq_i(irq_i), .waiting_o(waiting_o),
        .undef_op_o(undef_op_o), .regs_o(regs_o), .pc_o(pc_o),
        .ea_o(ea_o), .branch_cond_i_unused_o());
    c8dec_prog_mem u_mem (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .mem_addr_i(mem_addr_o), .mem_rd_i(mem_rd_o),
        .mem_rdata_o(mem_rdata_i));
    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_idle(output int n);
        n = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while (waiting_o !== 1'b1 && n < 200);
    endtask
    // program bytes sit left aligned: the top byte lands at address 0
    task automatic run(input logic [63:0] p, output int n);
        @(posedge ref_clk_i);
        rstn_i <= 1'b0;
        @(posedge ref_clk_i);
        for (int i = 0; i < 8; i++) u_mem.mem[i] = p[63 - 8 * i -: 8];
        @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        wait_idle(n);
    endtask
    task automatic t_tst();
        int n;
        u_mem.mem[16'h0010] = 8'h00;
        u_mem.mem[16'h0020] = 8'h80;
        run(64'h4d5d7d6d103d208f, n);
        chk("tst cycles", 16'h0015, n[15:0]);
        chk("tst flags", 16'h0004, 16'(regs_o.condition_code_reg));
        chk("dir address", 16'h0020, ea_o);
        chk("undefined flag", 16'h0000, 16'(undef_op_o));
        $display("t_tst done");
    endtask
    task automatic t_txa();
        int n;
        run(64'h9fa6814d9f8f0000, n);
        chk("txa data", 16'h0000, 16'(regs_o.a));
        chk("txa flags", 16'h0004, 16'(regs_o.condition_code_reg));
        $display("t_txa done");
    endtask
    task automatic t_modes();
        int n;
        logic [63:0] pg [6] = '{64'h9fc612348f000000, 64'h9fd601028f000000,
            64'h9fb6f08f00000000, 64'h9fe6ff8f00000000,
            64'h9ff68f0000000000, 64'h9fa6f0a43c8f0000};
        logic [15:0] ea [5] = '{16'h1234, 16'h0102, 16'h00f0, 16'h00ff,
            16'h0000};
        logic [7:0] av [6] = '{8'h3c, 8'h7e, 8'h0f, 8'haa, 8'h9f, 8'h30};
        u_mem.mem[16'h1234] = 8'h3c;
        u_mem.mem[16'h3412] = 8'hc3;
        u_mem.mem[16'h0102] = 8'h7e;
        u_mem.mem[16'h0201] = 8'he7;
        u_mem.mem[16'h00f0] = 8'h0f;
        u_mem.mem[16'h00ff] = 8'haa;
        for (int i = 0; i < 6; i++) begin
            run(pg[i], n);
            chk("mode data", 16'(av[i]), 16'(regs_o.a));
            if (i < 5) chk("mode address", ea[i], ea_o);
        end
        $display("t_modes done");
    endtask
    task automatic t_wait();
        int n;
        run(64'h9f8f4d8f00000000, n);
        chk("wait cycles", 16'h0004, n[15:0]);
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk("held", 16'h0001, 16'(waiting_o & ~mem_rd_o));
        @(posedge ref_clk_i);
        irq_i <= 1'b1;
        @(posedge ref_clk_i);
        irq_i <= 1'b0;
        wait_idle(n);
        chk("wake cycles", 16'h0005, n[15:0]);
        chk("wake flags", 16'h0002, 16'(regs_o.condition_code_reg));
        $display("t_wait done");
    endtask
    task automatic t_branch();
        int n;
        // forward then backward displacement, landing on a wait at 2
        run(64'h20048f00000020fa, n);
        chk("branch pc", 16'h0003, pc_o);
        chk("branch end", 16'h0001, 16'(waiting_o));
        $display("t_branch done");
    endtask
    initial begin
        @(posedge ref_clk_i);
        t_tst();
        t_txa();
        t_modes();
        t_wait();
        t_branch();
        test_done();
    end
    // the whole run needs under two hundred cycles
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            test_done();
        end
    end
endmodule // tb_cpu8_opcode_decode_tail
